// *** rtl/ocd_pkg.sv ***
// Purpose: Shared constants for the output channel data configuration block.
// Assumes: APB register indices; byte address is four times the index.
// Notes:   Register words are 16 bits wide in the low half of the bus.
package ocd_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH   = 4;
    localparam int WORD_W   = 10;
    localparam int REG_W    = 16;
    localparam int TRAIN_W  = 10;
    localparam int SAMP_W   = 3;
    localparam int TGT_W    = 8;
    localparam int MAN_W    = 9;
    localparam int CORR_W   = 11;
    localparam int WIN_SHIFT = 4;
    localparam int IRQ_W    = 2;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_RSVD_A   = 8'h60;
    localparam logic [7:0] IDX_RSVD_B   = 8'h61;
    localparam logic [7:0] IDX_POWER    = 8'h70;
    localparam logic [7:0] IDX_BLACK    = 8'h80;
    localparam logic [7:0] IDX_FORMAT   = 8'h81;
    localparam logic [7:0] IDX_TRAIN    = 8'h82;
    localparam logic [7:0] IDX_CAL_ERR  = 8'h90;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h91;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h92;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_CLK_EN  = 0;
    localparam int POS_SYNC_EN = 1;
    localparam int POS_DATA_EN = 2;
    localparam int POS_TARGET  = 0;
    localparam int POS_SAMP    = 8;
    localparam int POS_SEED    = 15;
    localparam int POS_AUTO    = 0;
    localparam int POS_MAN     = 1;
    localparam int POS_DEC     = 10;
    localparam int POS_NARROW  = 13;
    localparam int IRQ_CAL_ERR = 0;
    localparam int IRQ_APPLIED = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0]   RST_POWER  = 16'h0000;
    localparam logic [REG_W-1:0]   RST_BLACK  = 16'h4008;
    localparam logic [REG_W-1:0]   RST_FORMAT = 16'hc001;
    localparam logic [TRAIN_W-1:0] RST_TRAIN  = 10'h3a6;
    localparam logic [WORD_W-1:0]  CRC_POLY   = 10'h233;

    typedef enum logic [1:0] {
        OCD_ST_IDLE = 2'b00,
        OCD_ST_ACC  = 2'b01,
        OCD_ST_EVAL = 2'b11
    } ocd_cal_e;

endpackage : ocd_pkg

// *** rtl/ocd_cfg_if.sv ***
// Purpose: Frame-applied calibration settings passed to each channel.
// Assumes: Driven by the top from its shadow registers.
// Notes:   None.
`timescale 1ns/1ps
interface ocd_cfg_if;
    logic       auto_en;
    logic [2:0] samples;
    logic [7:0] target;
    logic [8:0] man_off;
    logic       man_dec;
    modport src (output auto_en, samples, target, man_off, man_dec);
    modport snk (input auto_en, samples, target, man_off, man_dec);
endinterface : ocd_cfg_if

// *** rtl/ocd_blackcal.sv ***
// Purpose: Per-channel black level calibration.
// Assumes: Frame start and end are one-cycle pulses on clk_sys.
// Notes:   Correction holds its last good value after an error.
`timescale 1ns/1ps
module ocd_blackcal
    import ocd_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    ocd_cfg_if.snk                 cfg,
    input  wire logic              frame_start,
    input  wire logic              frame_end,
    input  wire logic              blk_valid,
    input  wire logic [WORD_W-1:0] blk_data,
    output logic signed [CORR_W-1:0] corr,
    output logic                   err,
    output logic                   err_evt
);
    ocd_cal_e                state;
    logic [16:0]             sum;
    logic [7:0]              cnt;
    logic [7:0]              need;
    logic [WORD_W-1:0]       avg;
    logic signed [CORR_W-1:0] auto_corr;
    logic signed [CORR_W-1:0] man_corr;

    assign need     = 8'h01 << cfg.samples;
    assign avg      = WORD_W'(sum >> cfg.samples);
    assign man_corr = cfg.man_dec ? -$signed({2'b00, cfg.man_off})
                                  :  $signed({2'b00, cfg.man_off});

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= OCD_ST_IDLE;
            sum   <= 17'h00000;
            cnt   <= 8'h00;
        end else begin
            case (state)
                OCD_ST_IDLE: begin
                    if (frame_start) begin
                        sum   <= 17'h00000;
                        cnt   <= 8'h00;
                        state <= OCD_ST_ACC;
                    end
                end
                OCD_ST_ACC: begin
                    if (blk_valid && cnt < need) begin
                        sum <= sum + {7'h00, blk_data};
                        cnt <= cnt + 8'h01;
                    end
                    if (frame_end) begin
                        state <= OCD_ST_EVAL;
                    end
                end
                OCD_ST_EVAL: begin
                    state <= OCD_ST_IDLE;
                end
                default: begin
                    state <= OCD_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            auto_corr <= 11'h000;
            err       <= 1'b0;
            err_evt   <= 1'b0;
        end else begin
            err_evt <= 1'b0;
            if (state == OCD_ST_EVAL) begin
                if (cnt == need) begin
                    auto_corr <= $signed({3'b000, cfg.target})
                               - $signed({1'b0, avg});
                    err       <= 1'b0;
                end else begin
                    err     <= 1'b1;
                    err_evt <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            corr <= 11'h000;
        end else begin
            corr <= cfg.auto_en ? auto_corr : man_corr;
        end
    end

    a_short_err: assert property (@(posedge clk_sys) disable iff (!nrst)
        state == OCD_ST_EVAL && cnt < need |=> err && err_evt)
        else $error("Calibration error flag not raised");
    a_auto_target: assert property (@(posedge clk_sys) disable iff (!nrst)
        state == OCD_ST_EVAL && cnt == need |=>
        auto_corr == $signed({3'b000, $past(cfg.target)})
                   - $signed({1'b0, $past(avg)}))
        else $error("Automatic correction misses the target");
    a_manual_use: assert property (@(posedge clk_sys) disable iff (!nrst)
        !cfg.auto_en |=> corr == $past(man_corr))
        else $error("Manual offset not applied");
    a_auto_use: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.auto_en |=> corr == $past(auto_corr))
        else $error("Automatic correction not applied");
    c_cal_ok: cover property (@(posedge clk_sys) disable iff (!nrst)
        state == OCD_ST_EVAL && cnt == need);
endmodule : ocd_blackcal

// *** rtl/ocd_top.sv ***
// Purpose: Output lane power, black calibration and word formatting.
// Assumes: Pixel inputs on clk_sys; link clock is an asynchronous pin.
// Notes:   APB slave with zero wait states.
`timescale 1ns/1ps
module ocd_top
    import ocd_pkg::*;
#(
    parameter logic [WORD_W-1:0] POLY = CRC_POLY
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          irq,
    input  wire logic                     link_clk,
    input  wire logic                     frame_start,
    input  wire logic                     frame_end,
    input  wire logic                     pix_valid,
    input  wire logic                     pix_black,
    input  wire logic                     win_id,
    input  wire logic [NUM_CH*WORD_W-1:0] pix_data,
    output logic                          pix_ready,
    output logic                          clk_lane_en,
    output logic                          sync_lane_en,
    output logic                          data_lane_en,
    output logic                          clk_lane,
    output logic                          sync_lane,
    output logic [NUM_CH*WORD_W-1:0]      lane_word,
    output logic [NUM_CH*WORD_W-1:0]      lane_crc
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [2:0]         power;
    logic [REG_W-1:0]   black;
    logic [REG_W-1:0]   format;
    logic [TRAIN_W-1:0] train;
    logic [REG_W-1:0]   black_q;
    logic [REG_W-1:0]   format_q;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic [NUM_CH-1:0]  cal_err;
    logic [NUM_CH-1:0]  err_evt;
    logic               wr;
    logic               setup;
    logic [7:0]         idx;
    logic [IRQ_W-1:0]   irq_set;

    function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
        hit = (a[1:0] == 2'b00) && (a[11:10] == 2'b00) && (a[9:2] == i);
    endfunction : hit

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, IDX_RSVD_A) || hit(a, IDX_RSVD_B)
              || hit(a, IDX_POWER) || hit(a, IDX_BLACK)
              || hit(a, IDX_FORMAT) || hit(a, IDX_TRAIN)
              || hit(a, IDX_CAL_ERR) || hit(a, IDX_IRQ_STAT)
              || hit(a, IDX_IRQ_MASK);
    endfunction : mapped

    assign idx     = paddr[9:2];
    assign setup   = psel && !penable;
    assign pready  = psel && penable;
    assign pslverr = pready && !mapped(paddr);
    assign wr      = pready && pwrite && mapped(paddr);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            power  <= RST_POWER[2:0];
            black  <= RST_BLACK;
            format <= RST_FORMAT;
            train  <= RST_TRAIN;
            irq_mask <= 2'h0;
        end else if (wr) begin
            if (hit(paddr, IDX_POWER)) begin
                power <= pwdata[2:0];
            end
            if (hit(paddr, IDX_BLACK)) begin
                black <= pwdata[REG_W-1:0];
            end
            if (hit(paddr, IDX_FORMAT)) begin
                format <= pwdata[REG_W-1:0];
            end
            if (hit(paddr, IDX_TRAIN)) begin
                train <= pwdata[TRAIN_W-1:0];
            end
            if (hit(paddr, IDX_IRQ_MASK)) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            case (idx)
                IDX_POWER:    prdata <= {29'h0, power};
                IDX_BLACK:    prdata <= {16'h0000, black};
                IDX_FORMAT:   prdata <= {16'h0000, format};
                IDX_TRAIN:    prdata <= {22'h0, train};
                IDX_CAL_ERR:  prdata <= {28'h0, cal_err};
                IDX_IRQ_STAT: prdata <= {30'h0, irq_stat};
                IDX_IRQ_MASK: prdata <= {30'h0, irq_mask};
                default:      prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_set = {frame_start, |err_evt};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~((wr && hit(paddr, IDX_IRQ_STAT))
                        ? pwdata[IRQ_W-1:0] : 2'h0)) | irq_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------
    // Frame-boundary shadow of settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            black_q  <= RST_BLACK;
            format_q <= RST_FORMAT;
        end else if (frame_start) begin
            black_q  <= black;
            format_q <= format;
        end
    end

    ocd_cfg_if cfg ();
    assign cfg.auto_en = format_q[POS_AUTO];
    assign cfg.samples = black_q[POS_SAMP +: SAMP_W];
    assign cfg.target  = black_q[POS_TARGET +: TGT_W];
    assign cfg.man_off = format_q[POS_MAN +: MAN_W];
    assign cfg.man_dec = format_q[POS_DEC];

    // ------------------------------------------------------------------
    // Link clock sampling and lane power
    // ------------------------------------------------------------------
    logic link_s1;
    logic link_s2;
    logic link_s3;
    logic link_rise;
    logic take;
    logic narrow;
    logic [WIN_SHIFT-1:0] win_sr;
    logic win_now;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_s3 <= 1'b0;
        end else begin
            link_s1 <= link_clk;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
        end
    end

    assign link_rise    = link_s2 && !link_s3;
    assign pix_ready    = link_rise;
    assign take         = pix_valid && link_rise;
    assign narrow       = format_q[POS_NARROW];
    assign clk_lane_en  = power[POS_CLK_EN];
    assign sync_lane_en = power[POS_SYNC_EN];
    assign data_lane_en = power[POS_DATA_EN];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            win_sr  <= 4'h0;
            win_now <= 1'b0;
        end else if (link_rise) begin
            win_now <= take && win_id;
            win_sr  <= {win_sr[WIN_SHIFT-2:0], take && win_id};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_lane  <= 1'b0;
            sync_lane <= 1'b0;
        end else begin
            clk_lane  <= clk_lane_en && link_s2;
            sync_lane <= sync_lane_en
                       && (narrow ? win_sr[WIN_SHIFT-1] : win_now);
        end
    end

    // ------------------------------------------------------------------
    // Per-channel calibration, formatting and checksum
    // ------------------------------------------------------------------
    function automatic logic [WORD_W-1:0] crc_step(
        input logic [WORD_W-1:0] c, input logic [WORD_W-1:0] d);
        logic [WORD_W-1:0] r;
        r = c;
        for (int b = WORD_W - 1; b >= 0; b--) begin
            r = (r[WORD_W-1] ^ d[b]) ? ((r << 1) ^ POLY) : (r << 1);
        end
        crc_step = r;
    endfunction : crc_step

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic signed [CORR_W-1:0] corr;
            logic signed [11:0]       sum;
            logic [WORD_W-1:0]        clip;
            logic [WORD_W-1:0]        fmt;
            logic [WORD_W-1:0]        pix;

            assign pix = pix_data[ch*WORD_W +: WORD_W];

            ocd_blackcal u_cal (
                .clk_sys     (clk_sys),
                .nrst        (nrst),
                .cfg         (cfg),
                .frame_start (frame_start),
                .frame_end   (frame_end),
                .blk_valid   (take && pix_black),
                .blk_data    (pix),
                .corr        (corr),
                .err         (cal_err[ch]),
                .err_evt     (err_evt[ch])
            );

            assign sum  = $signed({2'b00, pix}) + 12'(corr);
            assign clip = sum[11] ? 10'h000 : (sum[10] ? 10'h3ff : sum[9:0]);
            assign fmt  = narrow ? {2'b00, clip[9:2]} : clip;

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    lane_word[ch*WORD_W +: WORD_W] <= 10'h000;
                end else if (!data_lane_en) begin
                    lane_word[ch*WORD_W +: WORD_W] <= 10'h000;
                end else if (take) begin
                    lane_word[ch*WORD_W +: WORD_W] <= fmt;
                end else if (link_rise) begin
                    lane_word[ch*WORD_W +: WORD_W] <= train;
                end
            end

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    lane_crc[ch*WORD_W +: WORD_W] <= 10'h000;
                end else if (frame_start) begin
                    lane_crc[ch*WORD_W +: WORD_W] <=
                        {WORD_W{black[POS_SEED]}};
                end else if (take) begin
                    lane_crc[ch*WORD_W +: WORD_W] <=
                        crc_step(lane_crc[ch*WORD_W +: WORD_W], fmt);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_clk_lane_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        !clk_lane_en |=> !clk_lane)
        else $error("Clock lane active while powered down");
    a_sync_lane_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        !sync_lane_en |=> !sync_lane)
        else $error("Sync lane active while powered down");
    a_data_lane_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        !data_lane_en |=> lane_word == '0)
        else $error("Data lanes active while powered down");
    a_idle_training: assert property (@(posedge clk_sys) disable iff (!nrst)
        data_lane_en && link_rise && !pix_valid
        |=> lane_word[WORD_W-1:0] == $past(train))
        else $error("Idle lane does not carry training word");
    a_narrow_word: assert property (@(posedge clk_sys) disable iff (!nrst)
        data_lane_en && take && narrow
        |=> lane_word[WORD_W-1:WORD_W-2] == 2'b00)
        else $error("Narrow word uses upper bits");
    a_crc_seed: assert property (@(posedge clk_sys) disable iff (!nrst)
        frame_start |=> lane_crc[WORD_W-1:0]
                        == {WORD_W{$past(black[POS_SEED])}})
        else $error("Checksum seed wrong at frame start");
    a_shadow_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !frame_start |=> $stable(format_q) && $stable(black_q))
        else $error("Settings changed inside a frame");
    a_err_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
        |err_evt |=> irq_stat[IRQ_CAL_ERR])
        else $error("Calibration error not reported");
    c_pix_take: cover property (@(posedge clk_sys) disable iff (!nrst)
        take && data_lane_en);
    c_narrow: cover property (@(posedge clk_sys) disable iff (!nrst)
        take && narrow && sync_lane_en);
    c_irq: cover property (@(posedge clk_sys) disable iff (!nrst)
        irq ##1 wr);

endmodule : ocd_top

// *** verification/ocd_rx_model.sv ***
// Purpose: Receiver model that aligns its words on the idle word.
// Assumes: Lane words are sampled on clk_sys.
// Notes:   Alignment stays set once all four lanes show the idle word.
`timescale 1ns/1ps
module ocd_rx_model
    import ocd_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic [TRAIN_W-1:0]       train,
    input  wire logic [NUM_CH*WORD_W-1:0] lane_word,
    output logic                          aligned
);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            aligned <= 1'b0;
        else if (lane_word == {NUM_CH{train}})
            aligned <= 1'b1;
    end
endmodule : ocd_rx_model

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the output channel block.
// Assumes: Zero wait state APB slave; link clock runs free.
// Notes:   Reads are noted in a queue and checked by a monitor.
`timescale 1ns/1ps
module tb
    import ocd_pkg::*;
;
    logic        clk_sys = '0, nrst = '0, link_clk = '0, psel = '0;
    logic        penable = '0, pwrite = '0, frame_start = '0;
    logic        frame_end = '0, pix_valid = '0, pix_black = '0;
    logic        win_id = '0, pready, pslverr, irq, pix_ready, aligned;
    logic        clk_lane, sync_lane, clk_lane_en, sync_lane_en;
    logic        data_lane_en;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [39:0] pix_data = '0, lane_word, lane_crc, crc_e = '0;
    logic [9:0]  t = 10'h155;
    logic [8:0]  po, no;
    logic [1:0]  pm;
    logic [32:0] expq[$];
    int          failures = 0, checks = 0, seed = 10167, i;
    always #12.5 clk_sys = ~clk_sys;
    always #100 link_clk = ~link_clk;
    ocd_top u_ocd_top (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .link_clk, .frame_start,
        .frame_end, .pix_valid, .pix_black, .win_id, .pix_data, .pix_ready,
        .clk_lane_en, .sync_lane_en, .data_lane_en, .clk_lane, .sync_lane,
        .lane_word, .lane_crc);
    ocd_rx_model u_ocd_rx_model (.clk_sys, .nrst, .train(t), .lane_word,
        .aligned);
    task cmp(input string n, input logic [39:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    function automatic logic [9:0] crc_f(input logic [9:0] c, d);
        for (int b = 9; b >= 0; b--)
            c = (c[9] ^ d[b]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        return c;
    endfunction : crc_f
    task give_up;
        failures++;
        end_of_test();
    endtask : give_up
    task apb(input logic w, input logic [7:0] a, input logic [32:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, a, 2'b00};
        pwdata <= d[31:0];
        if (!w) expq.push_back(d);
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk_sys);
        if (n == 20) give_up();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task chk_irq(input logic e);
        @(negedge clk_sys);
        cmp("irq", 40'(e), 40'(irq));
        @(posedge clk_sys);
    endtask : chk_irq
    task pix(input logic [8:0] o, input logic [1:0] m);
        logic [39:0] d, e;
        int n, k, v;
        d = 40'({$random(seed), $random(seed)});
        pix_data <= d;
        pix_valid <= 1'b1;
        win_id <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge clk_sys);
            if (pix_ready === 1'b1) break;
        end
        if (n == 20) give_up();
        @(posedge clk_sys);
        pix_valid <= 1'b0;
        win_id <= 1'b0;
        for (k = 0; k < 4; k++) begin
            v = int'(d[k*10+:10]) + (m[0] ? -int'(o) : int'(o));
            v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
            e[k*10+:10] = m[1] ? {2'b00, v[9:2]} : v[9:0];
            crc_e[k*10+:10] = crc_f(crc_e[k*10+:10], e[k*10+:10]);
        end
        @(negedge clk_sys);
        cmp("lane_word", e, lane_word);
        cmp("lane_crc", crc_e, lane_crc);
        @(posedge clk_sys);
        @(negedge clk_sys);
        if (!m[1]) cmp("sync_lane", 40'h1, 40'(sync_lane));
        @(posedge clk_sys);
    endtask : pix
    always @(posedge clk_sys)
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("prdata", 40'(expq.pop_front()), 40'({pslverr, prdata}));
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        apb(0, IDX_POWER, 33'h0);
        apb(0, IDX_BLACK, 33'h4008);
        apb(0, IDX_FORMAT, 33'hc001);
        apb(0, IDX_TRAIN, 33'h3a6);
        apb(0, IDX_RSVD_A, 33'h0);
        apb(0, 8'h50, 33'h100000000);
        apb(0, IDX_CAL_ERR, 33'h0);
        for (i = 0; i < 3; i++) begin
            apb(1, IDX_POWER, 33'(1 << i));
            @(negedge clk_sys);
            cmp("lane_en", 40'(1 << i),
                40'({data_lane_en, sync_lane_en, clk_lane_en}));
            @(posedge clk_sys);
        end
        apb(1, IDX_POWER, 33'h7);
        apb(1, IDX_TRAIN, 33'(t));
        apb(1, IDX_BLACK, 33'h8008);
        for (i = 0; i < 40 && aligned !== 1'b1; i++) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("aligned", 40'h1, 40'(aligned));
        cmp("idle", 40'({4{t}}), lane_word);
        @(posedge clk_sys);
        for (i = 0; i < 4; i++) begin
            no = 9'($random(seed));
            apb(1, IDX_FORMAT, 33'({i[1], 2'b00, i[0], no, 1'b0}));
            if (i > 0) pix(po, pm);
            frame_start <= 1'b1;
            crc_e = {40{1'b1}};
            @(posedge clk_sys);
            frame_start <= 1'b0;
            @(posedge clk_sys);
            cmp("crc_seed", crc_e, lane_crc);
            pix(no, 2'(i));
            po = no;
            pm = 2'(i);
        end
        frame_end <= 1'b1;
        @(posedge clk_sys);
        frame_end <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(0, IDX_CAL_ERR, 33'hf);
        chk_irq(1'b0);
        apb(0, IDX_IRQ_STAT, 33'h3);
        apb(1, IDX_IRQ_MASK, 33'h2);
        chk_irq(1'b1);
        apb(1, IDX_IRQ_STAT, 33'h2);
        chk_irq(1'b0);
        end_of_test();
    end
endmodule : tb
